// ### rgpc_top.sv
// pin configuration block for five general-purpose pins, remote drive on pins one to three
// assumes a classic wishbone master, 32-bit data, synchronous pad inputs
//
// The Wishbone slave port is implemented in this module.
`timescale 1ns/10ps
`default_nettype none
module rgpc_top
  import rgpc_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [rgpc_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  input  wire logic                  sel_strap_i,
  input  wire logic [2:0]            remote_val_i,
  input  wire logic [4:0]            func_val_i,
  input  wire logic [4:0]            pad_in_i,
  input  wire logic [2:0]            sec_pad_in_i,
  output logic      [4:0]            pad_out_o,
  output logic      [4:0]            pad_oe_n_o,
  output logic      [2:0]            sec_pad_out_o,
  output logic      [2:0]            sec_pad_oe_n_o
);

  rgpc_cfg_if cfg ();

  logic       req;
  logic       wr_ok;
  logic [7:0] idx;
  logic       wr_sel;
  logic       wr_one_two;
  logic       wr_three;
  logic       wr_five_six;
  logic [31:0] rd_next;
  logic [4:0] out_w;
  logic [4:0] oe_n_w;
  logic [4:0] gp_in_w;
  logic [4:0] in_level;
  logic [4:0] in_reg;
  logic [7:0] bit_dir;
  logic [7:0] bit_en;
  logic [7:0] bit_rem;
  logic [7:0] bit_val;

  // ---------------------------------------------------------------
  // wishbone slave: one wait state, ack drops after one cycle
  // ---------------------------------------------------------------
  assign req   = cyc_i && stb_i && !ack_o;
  assign idx   = adr_i[ADDR_W-1:2];
  assign wr_ok = req && we_i && sel_i[0];

  always_comb begin
    wr_sel      = 1'b0;
    wr_one_two  = 1'b0;
    wr_three    = 1'b0;
    wr_five_six = 1'b0;
    if (idx == PORT_SELECT_IDX) begin
      wr_sel = wr_ok;
    end else if (idx == PINS_ONE_TWO_IDX) begin
      wr_one_two = wr_ok;
    end else if (idx == PIN_THREE_IDX) begin
      wr_three = wr_ok;
    end else if (idx == PINS_FIVE_SIX_IDX) begin
      wr_five_six = wr_ok;
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    if (idx == PORT_SELECT_IDX) begin
      rd_next[0] = cfg.port_sel;
    end else if (idx == PINS_ONE_TWO_IDX) begin
      rd_next[7:0] = cfg.one_two;
    end else if (idx == PIN_THREE_IDX) begin
      rd_next[7:0] = cfg.three;
    end else if (idx == PINS_FIVE_SIX_IDX) begin
      rd_next[7:0] = cfg.five_six;
    end else if (idx == PIN_STATUS_IDX) begin
      rd_next[4:0] = in_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      dat_o <= rd_next;
    end
  end

  rgpc_regs u_regs (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .sel_strap_i   (sel_strap_i),
    .wr_sel_i      (wr_sel),
    .wr_one_two_i  (wr_one_two),
    .wr_three_i    (wr_three),
    .wr_five_six_i (wr_five_six),
    .wdata_i       (dat_i[7:0]),
    .cfg           (cfg.regs)
  );

  // ---------------------------------------------------------------
  // per-pin field gather: pins 1, 2, 3, 5, 6 at slots 0..4
  // ---------------------------------------------------------------
  always_comb begin
    bit_dir = {3'b000,
               cfg.five_six[HI_DIR_BIT], cfg.five_six[LO_DIR_BIT],
               cfg.three[LO_DIR_BIT],
               cfg.one_two[HI_DIR_BIT], cfg.one_two[LO_DIR_BIT]};
    bit_en  = {3'b000,
               cfg.five_six[HI_EN_BIT], cfg.five_six[LO_EN_BIT],
               cfg.three[LO_EN_BIT],
               cfg.one_two[HI_EN_BIT], cfg.one_two[LO_EN_BIT]};
    bit_rem = {5'b00000, cfg.three[LO_REM_BIT],
               cfg.one_two[HI_REM_BIT], cfg.one_two[LO_REM_BIT]};
    bit_val = {3'b000,
               cfg.five_six[HI_VAL_BIT], cfg.five_six[LO_VAL_BIT],
               cfg.three[LO_VAL_BIT],
               cfg.one_two[HI_VAL_BIT], cfg.one_two[LO_VAL_BIT]};
  end

  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
    rgpc_pads #(
      .HAS_REMOTE (p < 3)
    ) u_pad (
      .dir_i        (bit_dir[p]),
      .en_i         (bit_en[p]),
      .rem_i        (bit_rem[p]),
      .val_i        (bit_val[p]),
      .remote_val_i ((p < 3) ? remote_val_i[p % 3] : 1'b0),
      .func_val_i   (func_val_i[p]),
      .out_o        (out_w[p]),
      .oe_n_o       (oe_n_w[p]),
      .gp_in_o      (gp_in_w[p])
    );
  end

  // ---------------------------------------------------------------
  // pad routing: secondary pins take pins 1..3 under port select
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_out_o      <= 5'h00;
      pad_oe_n_o     <= 5'h1f;
      sec_pad_out_o  <= 3'h0;
      sec_pad_oe_n_o <= 3'h7;
    end else if (cfg.port_sel) begin
      sec_pad_out_o  <= out_w[2:0];
      sec_pad_oe_n_o <= oe_n_w[2:0];
      pad_out_o      <= {out_w[4:3], 3'h0};
      pad_oe_n_o     <= {oe_n_w[4:3], 3'h7};
    end else begin
      sec_pad_out_o  <= 3'h0;
      sec_pad_oe_n_o <= 3'h7;
      pad_out_o      <= out_w;
      pad_oe_n_o     <= oe_n_w;
    end
  end

  always_comb begin
    in_level = pad_in_i;
    if (cfg.port_sel) begin
      in_level[2:0] = sec_pad_in_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_reg <= 5'h00;
    end else begin
      in_reg <= in_level & gp_in_w;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_local_value_out : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!cfg.one_two[LO_REM_BIT] && !cfg.port_sel
      && cfg.one_two[1:0] == 2'b01 && !ack_o)
      |=> pad_out_o[0] == $past(cfg.one_two[LO_VAL_BIT])
        && !pad_oe_n_o[0])
    else $error("pin one did not drive its local value");

  a_remote_drive_on : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cfg.three[LO_REM_BIT] && !cfg.port_sel && !ack_o)
      |=> !pad_oe_n_o[2] && pad_out_o[2] == $past(remote_val_i[2]))
    else $error("remote value not driven on pin three");

  a_sec_remote_on : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cfg.one_two[LO_REM_BIT] && cfg.port_sel)
      |=> !sec_pad_oe_n_o[0]
        && sec_pad_out_o[0] == $past(remote_val_i[0]))
    else $error("remote value not driven on secondary pin one");

  a_remote_ignored : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!cfg.one_two[HI_REM_BIT] && cfg.one_two[5:4] == 2'b10
      && !cfg.port_sel && !ack_o) |=> pad_oe_n_o[1])
    else $error("pin two not tri-stated with remote off");

  a_pin_three_func : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!cfg.three[LO_REM_BIT] && cfg.three[1:0] == 2'b00 && !cfg.port_sel)
      |=> !pad_oe_n_o[2] && pad_out_o[2] == $past(func_val_i[2]))
    else $error("pin three not in functional output");

  a_func_mode_out : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cfg.five_six[1:0] == 2'b00 && !ack_o)
      |=> !pad_oe_n_o[3] && pad_out_o[3] == $past(func_val_i[3]))
    else $error("pin five not in functional output");

  a_gp_input_mode : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cfg.five_six[5:4] == 2'b11 && !ack_o) |=> pad_oe_n_o[4])
    else $error("pin six driven while in input mode");

  a_gp_in_status : assert property (
    @(posedge clk_i) disable iff (rst_i)
    cfg.five_six[5:4] == 2'b11 |=> in_reg[4] == $past(pad_in_i[4]))
    else $error("pin six input level not captured");

  a_status_masked : assert property (
    @(posedge clk_i) disable iff (rst_i)
    cfg.five_six[1:0] != 2'b11 |=> !in_reg[3])
    else $error("pin five status set outside input mode");

  // ---------------------------------------------------------------
  // routing and field pairing checks
  // ---------------------------------------------------------------
  a_secondary_route : assert property (
    @(posedge clk_i) disable iff (rst_i)
    cfg.port_sel && !ack_o |=> pad_oe_n_o[2:0] == 3'h7)
    else $error("primary pins driven under port select");

  a_primary_quiet : assert property (
    @(posedge clk_i) disable iff (rst_i)
    cfg.port_sel |=> pad_out_o[2:0] == 3'h0)
    else $error("primary pin level not low under port select");

  a_secondary_idle : assert property (
    @(posedge clk_i) disable iff (rst_i)
    !cfg.port_sel |=> sec_pad_oe_n_o == 3'h7 && sec_pad_out_o == 3'h0)
    else $error("secondary pins driven without port select");

  a_sec_gp_input : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cfg.port_sel && !cfg.one_two[HI_REM_BIT]
      && cfg.one_two[5:4] == 2'b11) |=> sec_pad_oe_n_o[1])
    else $error("secondary pin two driven in input mode");

  a_sec_pin_three : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cfg.port_sel && !cfg.three[LO_REM_BIT] && cfg.three[1:0] == 2'b01)
      |=> !sec_pad_oe_n_o[2]
        && sec_pad_out_o[2] == $past(cfg.three[LO_VAL_BIT]))
    else $error("secondary pin three did not drive its local value");

  a_upper_pin_code : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!cfg.port_sel && !cfg.one_two[HI_REM_BIT]
      && cfg.one_two[5:4] == 2'b01)
      |=> !pad_oe_n_o[1] && pad_out_o[1] == $past(cfg.one_two[HI_VAL_BIT]))
    else $error("pin two did not follow its upper code");

  a_lower_pin_code : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!cfg.port_sel && !cfg.three[LO_REM_BIT] && cfg.three[1:0] == 2'b10)
      |=> pad_oe_n_o[2])
    else $error("pin three not tri-stated by its lower code");

  a_no_remote_five : assert property (
    @(posedge clk_i) disable iff (rst_i)
    cfg.five_six[1:0] == 2'b01
      |=> !pad_oe_n_o[3] && pad_out_o[3] == $past(cfg.five_six[LO_VAL_BIT]))
    else $error("pin five local value overridden");

  a_no_remote_six : assert property (
    @(posedge clk_i) disable iff (rst_i)
    cfg.five_six[5:4] == 2'b01
      |=> !pad_oe_n_o[4] && pad_out_o[4] == $past(cfg.five_six[HI_VAL_BIT]))
    else $error("pin six local value overridden");

  // ---------------------------------------------------------------
  // bus and reset checks
  // ---------------------------------------------------------------
  a_bus_ack_once : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");

  a_bus_ack_next : assert property (
    @(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in the next cycle");

  a_read_pin_three : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !we_i && !ack_o && idx == PIN_THREE_IDX)
      |=> dat_o[31:4] == 28'h0)
    else $error("pin three register read upper bits");

  a_read_upper_zero : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !we_i && !ack_o) |=> dat_o[31:8] == 24'h0)
    else $error("read data above the register byte not zero");

  a_reset_quiet : assert property (
    @(posedge clk_i)
    rst_i |=> pad_oe_n_o == 5'h1f && sec_pad_oe_n_o == 3'h7 && !ack_o)
    else $error("outputs not released by reset");

endmodule
`default_nettype wire

// ### rgpc_pkg.sv
// package for the remote gpio pin configuration block
// assumes a classic wishbone slave with 32-bit data, one register a word
package rgpc_pkg;

  // ---------------------------------------------------------------
  // register word indices and address width
  // ---------------------------------------------------------------
  localparam logic [7:0] PINS_ONE_TWO_IDX  = 8'h1e;
  localparam logic [7:0] PIN_THREE_IDX     = 8'h1f;
  localparam logic [7:0] PINS_FIVE_SIX_IDX = 8'h20;
  localparam logic [7:0] PORT_SELECT_IDX   = 8'h30;
  localparam logic [7:0] PIN_STATUS_IDX    = 8'h31;
  localparam int         ADDR_W            = 10;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         LO_EN_BIT     = 0;
  localparam int         LO_DIR_BIT    = 1;
  localparam int         LO_REM_BIT    = 2;
  localparam int         LO_VAL_BIT    = 3;
  localparam int         HI_EN_BIT     = 4;
  localparam int         HI_DIR_BIT    = 5;
  localparam int         HI_REM_BIT    = 6;
  localparam int         HI_VAL_BIT    = 7;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] CFG_RESET_SEC = 8'h33;
  localparam logic [7:0] PIN3_RESET_SEC = 8'h03;
  localparam logic [7:0] PIN3_RW_MASK  = 8'h0f;
  localparam int         PIN_COUNT     = 5;

  // ---------------------------------------------------------------
  // pad modes from the {direction, enable} code
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RGPC_FUNC_OUT,
    RGPC_GP_OUT,
    RGPC_TRISTATE,
    RGPC_GP_IN
  } rgpc_mode_type;

  function automatic rgpc_mode_type rgpc_decode(input logic dir_b,
                                                input logic en_b);
    case ({dir_b, en_b})
      2'b00:   rgpc_decode = RGPC_FUNC_OUT;
      2'b01:   rgpc_decode = RGPC_GP_OUT;
      2'b10:   rgpc_decode = RGPC_TRISTATE;
      default: rgpc_decode = RGPC_GP_IN;
    endcase
  endfunction

endpackage

// ### rgpc_cfg_if.sv
// interface carrying stored pin settings from the register file
// assumes one producer (register file) and one consumer (pad logic)
`timescale 1ns/10ps
`default_nettype none
interface rgpc_cfg_if;
  logic [7:0] one_two;
  logic [7:0] three;
  logic [7:0] five_six;
  logic       port_sel;
  modport regs (output one_two, output three, output five_six,
                output port_sel);
  modport pads (input one_two, input three, input five_six,
                input port_sel);
endinterface
`default_nettype wire

// ### rgpc_regs.sv
// register file of the pin configuration block
// assumes decoded single-cycle write strobes from the bus slave
`timescale 1ns/10ps
`default_nettype none
module rgpc_regs
  import rgpc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sel_strap_i,
  input  wire logic       wr_sel_i,
  input  wire logic       wr_one_two_i,
  input  wire logic       wr_three_i,
  input  wire logic       wr_five_six_i,
  input  wire logic [7:0] wdata_i,
  rgpc_cfg_if.regs        cfg
);

  logic       sel_reg;
  logic [7:0] one_two_reg;
  logic [7:0] three_reg;
  logic [7:0] five_six_reg;
  logic       reload_reg;

  // ---------------------------------------------------------------
  // port select; reloads dir/enable defaults one cycle after reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg    <= 1'b0;
      reload_reg <= 1'b1;
    end else begin
      reload_reg <= 1'b0;
      if (reload_reg) begin
        sel_reg <= sel_strap_i;
      end else if (wr_sel_i) begin
        sel_reg <= wdata_i[0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      one_two_reg <= CFG_RESET;
    end else if (reload_reg) begin
      one_two_reg <= sel_strap_i ? CFG_RESET_SEC : CFG_RESET;
    end else if (wr_one_two_i) begin
      one_two_reg <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      three_reg <= CFG_RESET;
    end else if (reload_reg) begin
      three_reg <= sel_strap_i ? PIN3_RESET_SEC : CFG_RESET;
    end else if (wr_three_i) begin
      three_reg <= wdata_i & PIN3_RW_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      five_six_reg <= CFG_RESET;
    end else if (wr_five_six_i) begin
      five_six_reg <= wdata_i;
    end
  end

  assign cfg.one_two  = one_two_reg;
  assign cfg.three    = three_reg;
  assign cfg.five_six = five_six_reg;
  assign cfg.port_sel = sel_reg;

  a_pin3_upper_zero : assert property (
    @(posedge clk_i) disable iff (rst_i)
    three_reg[7:4] == 4'h0)
    else $error("pin three upper bits not zero");

  a_sec_reset_dir : assert property (
    @(posedge clk_i) disable iff (rst_i)
    (reload_reg && sel_strap_i) |=> (one_two_reg == CFG_RESET_SEC)
      && (three_reg == PIN3_RESET_SEC))
    else $error("secondary reset defaults not loaded");

  a_five_six_store : assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_five_six_i |=> five_six_reg == $past(wdata_i))
    else $error("pins five six register lost a write");

endmodule
`default_nettype wire

// ### rgpc_pads.sv
// pad control for one pin: mode decode and output choice
// assumes settings are stable registers and remote values synchronous
`timescale 1ns/10ps
`default_nettype none
module rgpc_pads
  import rgpc_pkg::*;
#(
  parameter bit HAS_REMOTE = 1'b1
) (
  input  wire logic dir_i,
  input  wire logic en_i,
  input  wire logic rem_i,
  input  wire logic val_i,
  input  wire logic remote_val_i,
  input  wire logic func_val_i,
  output logic      out_o,
  output logic      oe_n_o,
  output logic      gp_in_o
);

  rgpc_mode_type mode;
  logic          rem_on;

  always_comb begin
    mode   = rgpc_decode(dir_i, en_i);
    rem_on = HAS_REMOTE && rem_i;
    out_o  = 1'b0;
    oe_n_o = 1'b1;
    gp_in_o = 1'b0;
    if (rem_on) begin
      out_o  = remote_val_i;
      oe_n_o = 1'b0;
    end else begin
      case (mode)
        RGPC_FUNC_OUT: begin
          out_o  = func_val_i;
          oe_n_o = 1'b0;
        end
        RGPC_GP_OUT: begin
          out_o  = val_i;
          oe_n_o = 1'b0;
        end
        RGPC_TRISTATE: begin
          oe_n_o = 1'b1;
        end
        default: begin
          gp_in_o = 1'b1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### rgpc_remote_model.sv
// far-side model: remote serializer values for pins one to three
// assumes one clock with the block; hold_i freezes the value for checks
`timescale 1ns/10ps
`default_nettype none
module rgpc_remote_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       hold_i,
  output logic      [2:0] remote_val_o
);
  // new values arrive at random, sometimes every cycle, sometimes slowly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remote_val_o <= 3'h0;
    end else if (!hold_i && $urandom_range(3) != 0) begin
      remote_val_o <= 3'($urandom);
    end
  end
endmodule
`default_nettype wire

// ### rgpc_top_tb.sv
// self-checking testbench of the pin configuration block
// assumes rgpc_top with a classic wishbone slave and the remote model
`timescale 1ns/10ps
`default_nettype none
module rgpc_top_tb;
  import rgpc_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we = 1'b0;
  logic              strap = 1'b0;
  logic              hold = 1'b0;
  logic [3:0]        sel = 4'h0;
  logic [3:0]        be = 4'hf;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0]       dat = 32'h0;
  logic [31:0]       rdat;
  logic [31:0]       q;
  logic              ack;
  logic [4:0]        fv = 5'h0;
  logic [4:0]        pin = 5'h0;
  logic [4:0]        oe_n;
  logic [4:0]        pout;
  logic [2:0]        spin = 3'h0;
  logic [2:0]        rv;
  logic [2:0]        soe_n;
  logic [2:0]        sout;
  logic [7:0]        a;
  logic [7:0]        b;
  logic [7:0]        c;
  logic              s;
  int                mismatches = 0;
  int                comparisons = 0;
  logic [7:0]        corner [6] = '{8'h00, 8'h11, 8'h22, 8'h33, 8'hff, 8'h44};

  initial forever #4 clk = ~clk;

  rgpc_top dut_u (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .sel_i(sel), .adr_i(adr), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .sel_strap_i(strap), .remote_val_i(rv), .func_val_i(fv),
    .pad_in_i(pin), .sec_pad_in_i(spin), .pad_out_o(pout),
    .pad_oe_n_o(oe_n), .sec_pad_out_o(sout), .sec_pad_oe_n_o(soe_n)
  );

  rgpc_remote_model rmt_u (
    .clk_i(clk), .rst_i(rst), .hold_i(hold), .remote_val_o(rv)
  );

  // ---------------------------------------------------------------
  // expectations and checks
  // ---------------------------------------------------------------
  // nibble is {value, remote, direction, enable}; result is {oe_n, out}
  function automatic logic [1:0] pin_exp(logic [3:0] n, bit hr, logic r,
                                         logic f);
    if (hr && n[2]) return {1'b0, r};
    case (n[1:0])
      2'b00:   return {1'b0, f};
      2'b01:   return {1'b0, n[3]};
      default: return 2'b10;
    endcase
  endfunction

  // status bit: the pin level while in gpio input mode, else zero
  function automatic logic stat_exp(logic [3:0] n, bit hr, logic lvl);
    return !(hr && n[2]) && n[1:0] == 2'b11 && lvl;
  endfunction

  task automatic test_done();
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  // the output level only matters while the pad is driven
  task automatic chk_pad(int k, logic [1:0] e, logic oen, logic o);
    comparisons++;
    if (oen !== e[1] || (e[1] == 1'b0 && o !== e[0])) begin
      mismatches++;
      $display("unexpected pad%0d exp %b got %b", k, e, {oen, o});
    end
  endtask

  // ---------------------------------------------------------------
  // wishbone classic single cycle
  // ---------------------------------------------------------------
  task automatic wb(logic w, logic [7:0] idx, logic [7:0] d,
                    output logic [31:0] r);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= be;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      mismatches++;
      test_done();
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic check_all();
    logic [1:0] e [5];
    hold <= 1'b1;
    wb(0, PINS_ONE_TWO_IDX, 8'h0, q);
    chk_reg("cfg12", {24'h0, a}, q);
    wb(0, PIN_THREE_IDX, 8'h0, q);
    chk_reg("cfg3", {24'h0, b & 8'h0f}, q);
    wb(0, PINS_FIVE_SIX_IDX, 8'h0, q);
    chk_reg("cfg56", {24'h0, c}, q);
    wb(0, PORT_SELECT_IDX, 8'h0, q);
    chk_reg("psel", {31'h0, s}, q);
    wb(0, PIN_STATUS_IDX, 8'h0, q);
    chk_reg("status", {27'h0,
            stat_exp(c[7:4], 1'b0, pin[4]), stat_exp(c[3:0], 1'b0, pin[3]),
            stat_exp(b[3:0], 1'b1, s ? spin[2] : pin[2]),
            stat_exp(a[7:4], 1'b1, s ? spin[1] : pin[1]),
            stat_exp(a[3:0], 1'b1, s ? spin[0] : pin[0])}, q);
    e[0] = pin_exp(a[3:0], 1'b1, rv[0], fv[0]);
    e[1] = pin_exp(a[7:4], 1'b1, rv[1], fv[1]);
    e[2] = pin_exp(b[3:0], 1'b1, rv[2], fv[2]);
    e[3] = pin_exp(c[3:0], 1'b0, 1'b0, fv[3]);
    e[4] = pin_exp(c[7:4], 1'b0, 1'b0, fv[4]);
    for (int k = 0; k < 3; k++) begin
      chk_pad(k, s ? 2'b10 : e[k], oe_n[k], pout[k]);
      chk_pad(k + 5, s ? e[k] : 2'b10, soe_n[k], sout[k]);
    end
    for (int k = 3; k < 5; k++) begin
      chk_pad(k, e[k], oe_n[k], pout[k]);
    end
    hold <= 1'b0;
  endtask

  task automatic apply_cfg(logic [7:0] na, logic [7:0] nb, logic [7:0] nc,
                           logic ns);
    a = na;
    b = nb;
    c = nc;
    s = ns;
    fv   <= 5'($urandom);
    pin  <= 5'($urandom);
    spin <= 3'($urandom);
    wb(1, PINS_ONE_TWO_IDX, a, q);
    wb(1, PIN_THREE_IDX, b, q);
    wb(1, PINS_FIVE_SIX_IDX, c, q);
    wb(1, PORT_SELECT_IDX, {7'h0, s}, q);
    check_all();
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h1227));
    a = 8'h0;
    b = 8'h0;
    c = 8'h0;
    s = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check_all();
    for (int i = 0; i < 46; i++) begin
      if (i < 6) apply_cfg(corner[i], corner[i], corner[i], i[0]);
      else apply_cfg(8'($urandom), 8'($urandom), 8'($urandom), 1'($urandom));
    end
    wb(1, 8'h05, 8'hff, q);
    wb(0, 8'h05, 8'h0, q);
    chk_reg("unmapped", 32'h0, q);
    be = 4'he;
    wb(1, PINS_ONE_TWO_IDX, ~a, q);
    be = 4'hf;
    check_all();
    // strap high across a second reset gives the secondary defaults
    strap <= 1'b1;
    rst   <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    a = 8'h33;
    b = 8'h03;
    c = 8'h0;
    s = 1'b1;
    check_all();
    test_done();
  end
endmodule
`default_nettype wire
